// ---- hdl/cau_pkg.sv ----
// constants and carrier types of the capture / aux pwm unit
package cau_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int CNT_W     = 32;
	localparam int ADDR_W    = 8;
	localparam int NUM_SLOTS = 4;
	localparam int PTR_W     = 2;
	localparam int CTL_W     = 5;
	localparam int EVT_W     = 7;
	localparam int SYNC_W    = 4;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [ADDR_W-1:0] ADDR_COUNTER   = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_SLOT_BASE = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_SLOT_STEP = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CTL_TWO   = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_INT_STS   = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_INT_MSK   = 8'h1c;
	localparam logic [ADDR_W-1:0] ADDR_CLK_EN    = 8'h20;

	// ****************************************
	// control_reg_two fields
	// ****************************************
	localparam int CTL_MODE_BIT     = 0;
	localparam int CTL_RUN_BIT      = 1;
	localparam int CTL_SYNC_IN_BIT  = 2;
	localparam int CTL_SYNC_SEL_BIT = 3;
	localparam int CTL_FALL_BIT     = 4;
	localparam logic [CTL_W-1:0] CTL_RESET = 5'h02;

	// ****************************************
	// event bits (status and mask share this layout)
	// ****************************************
	localparam int EVT_CAP_BASE = 0;
	localparam int EVT_OVF_BIT  = 4;
	localparam int EVT_PRD_BIT  = 5;
	localparam int EVT_CMP_BIT  = 6;

	// ****************************************
	// timing and reset values
	// ****************************************
	localparam logic [SYNC_W-1:0] SYNC_OUT_CYCLES = 4'h8;
	localparam logic              CLK_EN_RESET    = 1'b0;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [CNT_W-1:0]  wdata;
	} cau_bus_req_t;

	typedef struct packed {
		logic [CNT_W-1:0]                cnt;
		logic [NUM_SLOTS-1:0][CNT_W-1:0] slot;
		logic [PTR_W-1:0]                ptr;
		logic [CTL_W-1:0]                ctl;
		logic [EVT_W-1:0]                sts;
		logic [EVT_W-1:0]                msk;
		logic                            clk_en;
		logic [1:0]                      cap_sync;
		logic [1:0]                      chn_sync;
		logic                            cap_prev;
		logic                            chn_prev;
		logic [SYNC_W-1:0]               sync_cnt;
		logic                            pwm;
		logic [CNT_W-1:0]                rdata;
	} cau_state_t;

endpackage

// ---- hdl/cau_top.sv ----
// capture channel with auxiliary asymmetric pwm mode
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ns

module cau_top
	import cau_pkg::*;
(
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	// register port
	input  wire cau_bus_req_t bus_i,
	output logic [CNT_W-1:0]  rdata_o,
	// pins and chain
	input  wire logic         capture_input_i,
	input  wire logic         chain_sync_input_i,
	output logic              chain_sync_output_o,
	output logic              aux_pwm_output_o,
	// interrupt
	output logic              module_interrupt_o
);

	// ****************************************
	// state
	// ****************************************
	cau_state_t q;
	cau_state_t d;

	// ****************************************
	// helper nets
	// ****************************************
	logic                            pwm_mode;
	logic                            running;
	logic                            cap_edge;
	logic                            chn_edge;
	logic                            cap_take;
	logic                            prd_hit;
	logic                            cmp_hit;
	logic                            ovf_hit;
	logic                            sync_in_clr;
	logic                            sync_trig;
	logic                            wr_cnt;
	logic                            wr_ctl;
	logic                            wr_sts;
	logic                            wr_msk;
	logic                            wr_clk;
	logic                            rd_cnt;
	logic                            rd_ctl;
	logic                            rd_sts;
	logic                            rd_msk;
	logic                            rd_clk;
	logic [EVT_W-1:0]                evt;
	logic [EVT_W-1:0]                clr;
	logic [EVT_W-1:0]                sts_next;
	logic [EVT_W-1:0]                irq_pend;
	logic [NUM_SLOTS-1:0]            slot_wr_hit;
	logic [NUM_SLOTS-1:0]            slot_rd_hit;
	logic [NUM_SLOTS-1:0]            slot_cap_hit;
	logic [NUM_SLOTS-1:0][CNT_W-1:0] slot_rd_part;
	logic [CNT_W-1:0]                cnt_step;
	logic [CNT_W-1:0]                cnt_next;
	logic [PTR_W-1:0]                ptr_next;
	logic                            pwm_next;
	logic [SYNC_W-1:0]               sync_next;
	logic [CNT_W-1:0]                rd_mux;

	// ****************************************
	// mode and gate
	// ****************************************
	// mode select
	assign pwm_mode = q.ctl[CTL_MODE_BIT];
	// unit gate
	// logical enable only: the register port still answers while stopped
	assign running  = q.clk_en & q.ctl[CTL_RUN_BIT];

	// ****************************************
	// edge detect
	// ****************************************
	// edge qualify
	assign cap_edge = q.ctl[CTL_FALL_BIT] ? (q.cap_prev & ~q.cap_sync[1])
		: (~q.cap_prev & q.cap_sync[1]);
	assign chn_edge = ~q.chn_prev & q.chn_sync[1];
	// edges count only while capturing and running
	assign cap_take = running & ~pwm_mode & cap_edge;

	// ****************************************
	// counter compare
	// ****************************************
	// active period and compare
	assign prd_hit  = pwm_mode & (q.cnt == q.slot[0]);
	assign cmp_hit  = pwm_mode & (q.cnt == q.slot[1]);
	assign ovf_hit  = ~pwm_mode & (q.cnt == {CNT_W{1'b1}});
	// up count only, back to zero at the period
	assign cnt_step = prd_hit ? '0 : q.cnt + CNT_W'(1);

	// ****************************************
	// sync chain
	// ****************************************
	// sync in clears counter
	assign sync_in_clr = running & q.ctl[CTL_SYNC_IN_BIT] & chn_edge;
	// with clk_en off a unit passes nothing on; with only the run bit clear it still relays sync in
	assign sync_trig   = q.clk_en
		& (q.ctl[CTL_SYNC_SEL_BIT] ? (running & prd_hit) : chn_edge);

	// ****************************************
	// register decode
	// ****************************************
	assign wr_cnt = bus_i.wr & (bus_i.addr == ADDR_COUNTER);
	assign wr_ctl = bus_i.wr & (bus_i.addr == ADDR_CTL_TWO);
	assign wr_sts = bus_i.wr & (bus_i.addr == ADDR_INT_STS);
	assign wr_msk = bus_i.wr & (bus_i.addr == ADDR_INT_MSK);
	assign wr_clk = bus_i.wr & (bus_i.addr == ADDR_CLK_EN);

	assign rd_cnt = bus_i.rd & (bus_i.addr == ADDR_COUNTER);
	assign rd_ctl = bus_i.rd & (bus_i.addr == ADDR_CTL_TWO);
	assign rd_sts = bus_i.rd & (bus_i.addr == ADDR_INT_STS);
	assign rd_msk = bus_i.rd & (bus_i.addr == ADDR_INT_MSK);
	assign rd_clk = bus_i.rd & (bus_i.addr == ADDR_CLK_EN);

	// ****************************************
	// slots
	// ****************************************
	// shared slots, one decode per slot
	for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
		localparam logic [ADDR_W-1:0] SLOT_ADDR = ADDR_W'(ADDR_SLOT_BASE + g * ADDR_SLOT_STEP);
		assign slot_wr_hit[g]  = bus_i.wr & (bus_i.addr == SLOT_ADDR);
		assign slot_rd_hit[g]  = bus_i.rd & (bus_i.addr == SLOT_ADDR);
		assign slot_cap_hit[g] = cap_take & (q.ptr == PTR_W'(g));
		assign slot_rd_part[g] = slot_rd_hit[g] ? q.slot[g] : '0;
	end

	// ****************************************
	// events
	// ****************************************
	// capture, pwm and counter events
	always_comb begin
		evt                            = '0;
		evt[EVT_CAP_BASE +: NUM_SLOTS] = slot_cap_hit;
		evt[EVT_OVF_BIT]               = running & ovf_hit;
		evt[EVT_PRD_BIT]               = running & prd_hit;
		evt[EVT_CMP_BIT]               = running & cmp_hit;
	end

	assign clr = wr_sts ? bus_i.wdata[EVT_W-1:0] : '0;
	// sticky flags: a set in the cycle of its clear wins
	for (genvar b = 0; b < EVT_W; b++) begin : g_sts
		assign sts_next[b] = evt[b] | (q.sts[b] & ~clr[b]);
	end

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		rd_mux = '0;
		for (int i = 0; i < NUM_SLOTS; i++) begin
			rd_mux = rd_mux | slot_rd_part[i];
		end
		if (rd_cnt) begin
			rd_mux = q.cnt;
		end
		if (rd_ctl) begin
			rd_mux = CNT_W'(q.ctl);
		end
		if (rd_sts) begin
			rd_mux = CNT_W'(q.sts);
		end
		if (rd_msk) begin
			rd_mux = CNT_W'(q.msk);
		end
		if (rd_clk) begin
			rd_mux = CNT_W'(q.clk_en);
		end
	end

	// ****************************************
	// counter next value
	// ****************************************
	always_comb begin
		cnt_next = q.cnt;
		if (running) begin
			cnt_next = cnt_step;
		end
		if (sync_in_clr) begin
			cnt_next = '0;
		end
		// a bus write wins over counting and sync in
		if (wr_cnt) begin
			cnt_next = bus_i.wdata;
		end
	end

	// ****************************************
	// slot pointer
	// ****************************************
	always_comb begin
		ptr_next = q.ptr;
		// pointer walks slot one to four, then wraps
		if (cap_take) begin
			ptr_next = q.ptr + PTR_W'(1);
		end
		// rewriting control_reg_two restarts the sequence at slot one
		if (wr_ctl) begin
			ptr_next = '0;
		end
	end

	// ****************************************
	// pwm output
	// ****************************************
	always_comb begin
		pwm_next = q.pwm;
		// output held low whenever capture mode is selected
		if (!pwm_mode) begin
			pwm_next = 1'b0;
		end else if (running && prd_hit) begin
			pwm_next = 1'b1;
		end else if (running && cmp_hit) begin
			pwm_next = 1'b0;
		end
	end

	// ****************************************
	// sync out stretch
	// ****************************************
	always_comb begin
		sync_next = q.sync_cnt;
		// a new trigger restarts the stretched pulse
		if (sync_trig) begin
			sync_next = SYNC_OUT_CYCLES;
		end else if (q.sync_cnt != '0) begin
			sync_next = q.sync_cnt - SYNC_W'(1);
		end
	end

	// ****************************************
	// combinational next state
	// ****************************************
	always_comb begin
		d = q;

		// synchronisers: first stage feeds only the second
		d.cap_sync = {q.cap_sync[0], capture_input_i};
		d.chn_sync = {q.chn_sync[0], chain_sync_input_i};
		d.cap_prev = q.cap_sync[1];
		d.chn_prev = q.chn_sync[1];

		d.cnt      = cnt_next;
		d.ptr      = ptr_next;
		d.pwm      = pwm_next;
		d.sync_cnt = sync_next;
		d.sts      = sts_next;

		// shadow transfer at the period match
		// slot three shadows period, slot four shadows compare
		if (running && prd_hit) begin
			d.slot[0] = q.slot[2];
			d.slot[1] = q.slot[3];
		end
		for (int i = 0; i < NUM_SLOTS; i++) begin
			if (slot_cap_hit[i]) begin
				d.slot[i] = q.cnt;
			end
		end
		// software writes reach the slots in either mode
		for (int i = 0; i < NUM_SLOTS; i++) begin
			if (slot_wr_hit[i]) begin
				d.slot[i] = bus_i.wdata;
			end
		end

		if (wr_ctl) begin
			d.ctl = bus_i.wdata[CTL_W-1:0];
		end
		if (wr_msk) begin
			d.msk = bus_i.wdata[EVT_W-1:0];
		end
		if (wr_clk) begin
			d.clk_en = bus_i.wdata[0];
		end

		// read data stands only in the cycle after the strobe
		d.rdata = bus_i.rd ? rd_mux : '0;
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q        <= '0;
			q.ctl    <= CTL_RESET;
			q.clk_en <= CLK_EN_RESET;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign rdata_o             = q.rdata;
	assign aux_pwm_output_o    = q.pwm;
	assign chain_sync_output_o = q.sync_cnt != '0;
	assign irq_pend            = q.sts & q.msk;
	assign module_interrupt_o  = |irq_pend;

endmodule

// ---- tb/cau_checker.sv ----
// port assertions of the capture / aux pwm unit
`timescale 1ns/1ns
module cau_checker
	import cau_pkg::*;
(
	// watched ports
	input wire logic             clk_i,
	input wire logic             rst_b_i,
	input wire cau_bus_req_t     bus_i,
	input wire logic [CNT_W-1:0] rdata_o,
	input wire logic             chain_sync_output_o,
	input wire logic             aux_pwm_output_o,
	input wire logic             module_interrupt_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_rdz; !$past(bus_i.rd) |-> rdata_o == '0; endproperty
	a_rdz: assert property (p_rdz) else $error("stray read data");
	property p_unm; bus_i.rd && bus_i.addr == 8'h40 |=> rdata_o == '0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_en; bus_i.rd && bus_i.addr == ADDR_CLK_EN |=> rdata_o[CNT_W-1:1] == '0; endproperty
	a_en: assert property (p_en) else $error("enable upper bits set");
	property p_msk; bus_i.wr && bus_i.addr == ADDR_INT_MSK ##2 bus_i.rd && bus_i.addr ==
		ADDR_INT_MSK |=> rdata_o[EVT_W-1:0] == $past(bus_i.wdata[EVT_W-1:0], 3); endproperty
	a_msk: assert property (p_msk) else $error("mask readback wrong");
	property p_off; bus_i.wr && bus_i.addr == ADDR_INT_MSK && bus_i.wdata[EVT_W-1:0] == '0
		|=> !module_interrupt_o; endproperty
	a_off: assert property (p_off) else $error("masked interrupt high");
	property p_cap; bus_i.wr && bus_i.addr == ADDR_CTL_TWO && !bus_i.wdata[CTL_MODE_BIT]
		|=> ##1 !aux_pwm_output_o; endproperty
	a_cap: assert property (p_cap) else $error("pwm output in capture mode");
	property p_srs; $rose(chain_sync_output_o) |-> chain_sync_output_o[*8]; endproperty
	a_srs: assert property (p_srs) else $error("sync pulse short");
	property p_sfl; $fell(chain_sync_output_o) |-> $past(chain_sync_output_o, 8); endproperty
	a_sfl: assert property (p_sfl) else $error("sync pulse cut");
endmodule

bind cau_top cau_checker u_chk (.clk_i, .rst_b_i, .bus_i, .rdata_o,
	.chain_sync_output_o, .aux_pwm_output_o, .module_interrupt_o);

// ---- tb/cau_far_end.sv ----
// far side: capture pin and neighbour sync source
`timescale 1ns/1ns
module cau_far_end (
	// pins toward the unit
	input  wire logic clk_i,
	output logic      capture_input_o,
	output logic      chain_sync_o
);
	initial begin
		capture_input_o = 1'b0;
		chain_sync_o    = 1'b0;
	end
	// three-cycle pulses, wider than the one the pins need
	task automatic pulse(input bit sync);
		@(posedge clk_i);
		if (sync) chain_sync_o <= 1'b1;
		else capture_input_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		chain_sync_o    <= 1'b0;
		capture_input_o <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
endmodule

// ---- tb/tb_cau_top.sv ----
// self-checking bench of the capture / aux pwm unit
`timescale 1ns/1ns
module tb_cau_top;
	import cau_pkg::*;
	typedef struct packed {logic [7:0] a; logic [31:0] w, e;} cau_row_t;
	logic             clk_i = 1'b0;
	logic             rst_b_i = 1'b0;
	cau_bus_req_t     bus_i = '0;
	logic [CNT_W-1:0] rdata_o, d, s, hi, hs;
	logic             cap, syn, so, pwm, irq;
	int               n_mismatch = 0;
	int               checks = 0;
	cau_row_t rows [5] = '{'{ADDR_INT_MSK, 32'hffffffff, 32'h0000007f},
		'{ADDR_CLK_EN, 32'hffffffff, 32'h00000001}, '{8'h10, 32'ha5a5a5a5, 32'ha5a5a5a5},
		'{8'h40, 32'hffffffff, 32'h0}, '{ADDR_CTL_TWO, 32'hffffffff, 32'h0000001f}};
	always #25 clk_i = ~clk_i;
	cau_top u_dut (.clk_i, .rst_b_i, .bus_i, .rdata_o, .capture_input_i(cap),
		.chain_sync_input_i(syn), .chain_sync_output_o(so), .aux_pwm_output_o(pwm),
		.module_interrupt_o(irq));
	cau_far_end u_far (.clk_i, .capture_input_o(cap), .chain_sync_o(syn));
	task automatic cmp(input logic [31:0] g, e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		@(posedge clk_i);
		bus_i <= '{1'b1, 1'b0, a, w};
		@(posedge clk_i);
		bus_i <= '0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		bus_i <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clk_i);
		bus_i <= '0;
		#1 d = rdata_o;
	endtask
	// two periods of output and sync pulses after new shadows load
	task automatic pwm_run(input logic [31:0] p, c, x);
		wr(8'h0c, p);
		wr(8'h10, c);
		repeat (16) @(posedge clk_i);
		hi = '0;
		hs = '0;
		repeat (2 * (p + 1)) @(negedge clk_i) begin
			hi += pwm;
			hs += so;
		end
		cmp(hi, x);
		cmp(hs, 32'h10);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#100us;
		n_mismatch++;
		summarize;
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(ADDR_CTL_TWO);
		cmp(d, 32'h2);
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].w);
			rd(rows[k].a);
			cmp(d, rows[k].e);
		end
		wr(ADDR_CTL_TWO, 32'h2);
		wr(ADDR_INT_STS, 32'h7f);
		wr(ADDR_INT_MSK, 32'hf);
		repeat (4) u_far.pulse(1'b0);
		rd(ADDR_INT_STS);
		cmp(d & 32'hf, 32'hf);
		cmp({31'h0, irq}, 32'h1);
		wr(ADDR_INT_MSK, 32'h0);
		#1 cmp({31'h0, irq}, 32'h0);
		wr(ADDR_INT_MSK, 32'hf);
		rd(ADDR_SLOT_BASE);
		s = d;
		rd(8'h10);
		cmp(d - s, 32'h15);
		wr(ADDR_INT_STS, 32'hf);
		#1 cmp({31'h0, irq}, 32'h0);
		wr(ADDR_CTL_TWO, 32'h6);
		u_far.pulse(1'b1);
		rd(ADDR_COUNTER);
		cmp({31'h0, d < 32'h10}, 32'h1);
		wr(ADDR_SLOT_BASE, 32'h9);
		wr(8'h08, 32'h4);
		wr(ADDR_CTL_TWO, 32'hb);
		wr(ADDR_COUNTER, 32'h0);
		pwm_run(32'h9, 32'h4, 32'ha);
		pwm_run(32'hd, 32'h2, 32'h6);
		wr(ADDR_CLK_EN, 32'h0);
		rd(ADDR_COUNTER);
		s = d;
		rd(ADDR_COUNTER);
		cmp(d, s);
		// mid-run reset brings control and enable back to their reset values
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(ADDR_CTL_TWO);
		cmp(d, 32'h00000002);
		rd(ADDR_CLK_EN);
		cmp(d, 32'h00000000);
		summarize;
	end
endmodule
